// ==== hdl/twp_defines.svh ====
`ifndef TWP_DEFINES_SVH
`define TWP_DEFINES_SVH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define TWP_OFS_CTRL     12'h000
`define TWP_OFS_VAL0     12'h010
`define TWP_OFS_VAL1     12'h014
`define TWP_OFS_MSK0     12'h020
`define TWP_OFS_MSK1     12'h024
`define TWP_OFS_CNT      12'h030
`define TWP_OFS_ACT0     12'h040
`define TWP_OFS_ACT15    12'h07C

// -----------------------------------------------------------------
// update control fields
// -----------------------------------------------------------------
`define TWP_CMD_LSB      0
`define TWP_CMD_W        3
`define TWP_CMD_WRITE    3'h4
`define TWP_ADDR_LSB     3
`define TWP_ADDR_W       16
`define TWP_TSEL_BIT     19
`define TWP_WIPE_BIT     20
`define TWP_BUSY_BIT     21

// -----------------------------------------------------------------
// cache word layouts and table limits
// -----------------------------------------------------------------
`define TWP_CLM_VAL_HI   20
`define TWP_CLM_ACT_HI   14
`define TWP_ES_VAL_HI    19
`define TWP_ES_ACT_HI    9
`define TWP_ES_LAST      16'h0FFF

// -----------------------------------------------------------------
// timing, bus transfer code and reset values
// -----------------------------------------------------------------
`define TWP_CLK_NS       10
`define TWP_COMMIT_NS    40
`define TWP_COMMIT_CYC   (`TWP_COMMIT_NS / `TWP_CLK_NS)
`define TWP_HTRANS_NONSEQ 2'h2
`define TWP_WORD_RST     32'h0000_0000

`endif

// ==== hdl/twp_pkg.sv ====
package twp_pkg;

  typedef enum logic [1:0] {
    TWP_ST_IDLE = 2'b01,
    TWP_ST_BUSY = 2'b10
  } twp_state_t;

  typedef struct packed {
    logic        valid;
    logic [109:0] action;
    logic [51:0] mask;
    logic [51:0] value;
  } twp_clm_rule_t;

  typedef struct packed {
    logic        valid;
    logic [488:0] action;
    logic [50:0] mask;
    logic [50:0] value;
  } twp_es_rule_t;

  typedef struct packed {
    logic        valid;
    logic        tsel;
    logic [15:0] addr;
    logic [51:0] key;
  } twp_lookup_t;

endpackage

// ==== hdl/twp_rule_ram.sv ====
`timescale 1ns/1ps

module twp_rule_ram #(
  parameter int DEPTH = 4096,
  parameter int WIDTH = 592,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk,
  input  wire logic             ce,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             re,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2 || WIDTH < 1) begin : g_chk
    $error("twp_rule_ram: bad DEPTH or WIDTH");
  end

  // no reset on the array: software deletes rules by writing a wiped cache
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
    if (ce && re) begin
      rdata <= mem[raddr];
    end
  end

endmodule

// ==== hdl/twp_rule_write_port.sv ====
`timescale 1ns/1ps
`include "twp_defines.svh"

module twp_rule_write_port #(
  parameter int CLM_DEPTH     = 9216,
  parameter int ES_DEPTH      = 4096,
  parameter int COMMIT_CYCLES = `TWP_COMMIT_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic      [31:0]          hrdata,
  output logic                      hresp,
  input  wire twp_pkg::twp_lookup_t lookup_req,
  output logic                      lookup_done,
  output logic                      lookup_hit,
  output logic      [488:0]         lookup_result
);
  import twp_pkg::*;

  localparam int CLM_AW = $clog2(CLM_DEPTH);
  localparam int ES_AW  = $clog2(ES_DEPTH);

  if (CLM_DEPTH < 2 || CLM_DEPTH > 65536 || ES_DEPTH < 2 || ES_DEPTH > 4096 || COMMIT_CYCLES < 1
      || COMMIT_CYCLES > 255) begin : g_chk
    $error("twp_rule_write_port: parameter out of range");
  end

  // -----------------------------------------------------------------
  // bus slave: address phase capture
  // -----------------------------------------------------------------
  logic        dp_wr_r;
  logic [11:0] dp_ofs_r;
  wire         ap_take = hsel && hready && htrans == `TWP_HTRANS_NONSEQ;
  wire  [11:0] ap_ofs  = haddr[11:0];
  wire         ap_hi   = haddr[31:12] != 20'h0_0000;

  // -----------------------------------------------------------------
  // cache and commit state
  // -----------------------------------------------------------------
  logic [31:0] val_r [2];
  logic [31:0] msk_r [2];
  logic [31:0] act_r [16];
  logic        cnt_r;
  twp_state_t  st_r;
  logic [7:0]  wait_r;
  logic        busy_r;
  logic        tsel_r;
  logic [15:0] tgt_r;

  // data phase decode
  wire         dp_ctrl  = dp_wr_r && dp_ofs_r == `TWP_OFS_CTRL;
  wire         dp_cache = dp_wr_r && !busy_r;
  wire         dp_act   = dp_ofs_r >= `TWP_OFS_ACT0 && dp_ofs_r <= `TWP_OFS_ACT15;
  wire  [3:0]  dp_aidx  = 4'((dp_ofs_r - `TWP_OFS_ACT0) >> 2);
  wire         do_wipe  = dp_ctrl && !busy_r && hwdata[`TWP_WIPE_BIT];
  wire         do_cmd   = dp_ctrl && !busy_r
                          && hwdata[`TWP_CMD_LSB +: `TWP_CMD_W] == `TWP_CMD_WRITE;
  wire         st_done  = st_r == TWP_ST_BUSY && wait_r == 8'h00;

  // -----------------------------------------------------------------
  // read mux, decided in the address phase so data is registered
  // -----------------------------------------------------------------
  wire  [3:0]  ap_aidx  = 4'((ap_ofs - `TWP_OFS_ACT0) >> 2);
  wire         ap_act   = ap_ofs >= `TWP_OFS_ACT0 && ap_ofs <= `TWP_OFS_ACT15;
  wire  [31:0] ctrl_rd  = {10'h000, busy_r, 1'b0, tsel_r, tgt_r, 3'h0};
  wire  [31:0] rd_word  = ap_hi                        ? 32'h0000_0000 :
                          ap_ofs == `TWP_OFS_CTRL      ? ctrl_rd :
                          ap_ofs == `TWP_OFS_VAL0      ? val_r[0] :
                          ap_ofs == `TWP_OFS_VAL1      ? val_r[1] :
                          ap_ofs == `TWP_OFS_MSK0      ? msk_r[0] :
                          ap_ofs == `TWP_OFS_MSK1      ? msk_r[1] :
                          ap_ofs == `TWP_OFS_CNT       ? {31'h0000_0000, cnt_r} :
                          ap_act && ap_ofs[1:0] == 2'h0 ? act_r[ap_aidx] : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dp_wr_r   <= 1'b0;
      dp_ofs_r  <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= `TWP_WORD_RST;
    end else if (ce) begin
      dp_wr_r   <= ap_take && hwrite && !ap_hi;
      dp_ofs_r  <= ap_ofs;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= (ap_take && !hwrite) ? rd_word : `TWP_WORD_RST;
    end
  end

  // -----------------------------------------------------------------
  // cache words
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || (ce && do_wipe)) begin
      val_r <= '{default: `TWP_WORD_RST};
      msk_r <= '{default: `TWP_WORD_RST};
      act_r <= '{default: `TWP_WORD_RST};
      cnt_r <= 1'b0;
    end else if (ce && dp_cache) begin
      if (dp_ofs_r == `TWP_OFS_VAL0) val_r[0] <= hwdata;
      if (dp_ofs_r == `TWP_OFS_VAL1) val_r[1] <= hwdata;
      if (dp_ofs_r == `TWP_OFS_MSK0) msk_r[0] <= hwdata;
      if (dp_ofs_r == `TWP_OFS_MSK1) msk_r[1] <= hwdata;
      if (dp_ofs_r == `TWP_OFS_CNT)  cnt_r    <= hwdata[0];
      if (dp_act && dp_ofs_r[1:0] == 2'h0) act_r[dp_aidx] <= hwdata;
    end
  end

  // -----------------------------------------------------------------
  // commit sequencer
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r   <= TWP_ST_IDLE;
      wait_r <= 8'h00;
      busy_r <= 1'b0;
      tsel_r <= 1'b0;
      tgt_r  <= 16'h0000;
    end else if (ce) begin
      unique case (st_r)
        TWP_ST_IDLE: begin
          if (do_cmd) begin
            st_r   <= TWP_ST_BUSY;
            busy_r <= 1'b1;
            wait_r <= 8'(COMMIT_CYCLES - 1);
            tsel_r <= hwdata[`TWP_TSEL_BIT];
            tgt_r  <= hwdata[`TWP_ADDR_LSB +: `TWP_ADDR_W];
          end
        end
        TWP_ST_BUSY: begin
          if (st_done) begin
            st_r   <= TWP_ST_IDLE;
            busy_r <= 1'b0;
          end else begin
            wait_r <= wait_r - 8'h01;
          end
        end
        default: begin
          st_r   <= TWP_ST_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // rule assembly from the cache
  // -----------------------------------------------------------------
  twp_clm_rule_t clm_wr;
  twp_es_rule_t  es_wr;
  logic [479:0]  es_act_lo;

  for (genvar i = 0; i < 15; i++) begin : g_es_act
    assign es_act_lo[i*32 +: 32] = act_r[i];
  end

  assign clm_wr.value  = {val_r[1][`TWP_CLM_VAL_HI-1:0], val_r[0]};
  assign clm_wr.mask   = {msk_r[1][`TWP_CLM_VAL_HI-1:0], msk_r[0]};
  assign clm_wr.action = {act_r[3][`TWP_CLM_ACT_HI-1:0], act_r[2], act_r[1], act_r[0]};
  // an all-zero value and mask marks a deleted address that never matches
  assign clm_wr.valid  = |{clm_wr.value, clm_wr.mask};
  assign es_wr.value   = {val_r[1][`TWP_ES_VAL_HI-1:0], val_r[0]};
  assign es_wr.mask    = {msk_r[1][`TWP_ES_VAL_HI-1:0], msk_r[0]};
  assign es_wr.action  = {act_r[15][`TWP_ES_ACT_HI-1:0], es_act_lo};
  assign es_wr.valid   = |{es_wr.value, es_wr.mask};

  wire clm_in   = 32'(tgt_r) < CLM_DEPTH;
  wire es_in    = tgt_r <= `TWP_ES_LAST && 32'(tgt_r) < ES_DEPTH;
  wire clm_we   = st_done && !tsel_r && clm_in;
  wire es_we    = st_done && tsel_r && es_in;

  // -----------------------------------------------------------------
  // lookup path: read stored rule, then ternary compare
  // -----------------------------------------------------------------
  twp_clm_rule_t clm_rd;
  twp_es_rule_t  es_rd;
  logic          lk_v_r;
  logic          lk_ok_r;
  logic          lk_tsel_r;
  logic [51:0]   lk_key_r;

  wire lk_clm_ok = 32'(lookup_req.addr) < CLM_DEPTH;
  wire lk_es_ok  = lookup_req.addr <= `TWP_ES_LAST && 32'(lookup_req.addr) < ES_DEPTH;
  wire lk_ok     = lookup_req.tsel ? lk_es_ok : lk_clm_ok;

  twp_rule_ram #(.DEPTH(CLM_DEPTH), .WIDTH($bits(twp_clm_rule_t))) u_clm_ram (
    .clk   (clk),
    .ce    (ce),
    .we    (clm_we),
    .waddr (tgt_r[CLM_AW-1:0]),
    .wdata (clm_wr),
    .re    (lookup_req.valid && !lookup_req.tsel && lk_clm_ok),
    .raddr (lookup_req.addr[CLM_AW-1:0]),
    .rdata (clm_rd)
  );

  twp_rule_ram #(.DEPTH(ES_DEPTH), .WIDTH($bits(twp_es_rule_t))) u_es_ram (
    .clk   (clk),
    .ce    (ce),
    .we    (es_we),
    .waddr (tgt_r[ES_AW-1:0]),
    .wdata (es_wr),
    .re    (lookup_req.valid && lookup_req.tsel && lk_es_ok),
    .raddr (lookup_req.addr[ES_AW-1:0]),
    .rdata (es_rd)
  );

  // a set mask bit is a wildcard; type-group bits rely on software zero masks
  wire clm_match = clm_rd.valid && ((clm_rd.value ^ lk_key_r) & ~clm_rd.mask) == 52'h0;
  wire es_match  = es_rd.valid && ((es_rd.value ^ lk_key_r[50:0]) & ~es_rd.mask) == 51'h0;
  wire lk_hit    = lk_ok_r && (lk_tsel_r ? es_match : clm_match);
  wire [488:0] lk_res = lk_tsel_r ? es_rd.action : {379'h0, clm_rd.action};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lk_v_r        <= 1'b0;
      lk_ok_r       <= 1'b0;
      lk_tsel_r     <= 1'b0;
      lk_key_r      <= 52'h0;
      lookup_done   <= 1'b0;
      lookup_hit    <= 1'b0;
      lookup_result <= 489'h0;
    end else if (ce) begin
      lk_v_r        <= lookup_req.valid;
      lk_ok_r       <= lookup_req.valid && lk_ok;
      lk_tsel_r     <= lookup_req.tsel;
      lk_key_r      <= lookup_req.key;
      lookup_done   <= lk_v_r;
      lookup_hit    <= lk_v_r && lk_hit;
      lookup_result <= (lk_v_r && lk_hit) ? lk_res : 489'h0;
    end
  end

endmodule

// ==== verification/twp_rule_write_port_chk.sv ====
`timescale 1ns/1ps

module twp_rule_write_port_chk #(
  parameter int CLM_DEPTH = 9216
) (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 ce,
  input wire logic                 hsel,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic                 hready,
  input wire logic                 hreadyout,
  input wire logic [31:0]          hrdata,
  input wire logic                 hresp,
  input wire twp_pkg::twp_lookup_t lookup_req,
  input wire logic                 lookup_done,
  input wire logic                 lookup_hit,
  input wire logic [488:0]         lookup_result
);
  import twp_pkg::*;
  // ----------------------------------------
  // lookup and bus relations
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_look_latency: assert property (lookup_req.valid && ce |-> ##2 lookup_done)
    else $error("lookup answer missing two cycles after request");
  chk_done_cause: assert property (lookup_done |-> $past(lookup_req.valid && ce, 2))
    else $error("lookup answer without request");
  chk_hit_pair: assert property (lookup_hit |-> lookup_done)
    else $error("hit outside answer cycle");
  chk_miss_zero: assert property (lookup_done && !lookup_hit |-> lookup_result == '0)
    else $error("result not zero on miss");
  chk_es_range: assert property (lookup_req.valid && ce && lookup_req.tsel && lookup_req.addr > 16'h0FFF
    |-> ##2 !lookup_hit)
    else $error("egress hit beyond its address range");
  chk_clm_range: assert property (lookup_req.valid && ce && !lookup_req.tsel && lookup_req.addr >= CLM_DEPTH
    |-> ##2 !lookup_hit)
    else $error("classification hit beyond its depth");
  chk_clm_width: assert property (lookup_done && $past(!lookup_req.tsel, 2) |-> lookup_result[488:110] == '0)
    else $error("classification result wider than its action");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  // read data only ever follows a read address phase
  chk_rdata_idle: assert property (hrdata != '0 |-> $past(hsel && hready && htrans == 2'h2 && !hwrite && ce))
    else $error("read data outside read data phase");
endmodule

bind twp_rule_write_port twp_rule_write_port_chk #(.CLM_DEPTH(CLM_DEPTH)) chk_u (
  .clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .lookup_req(lookup_req),
  .lookup_done(lookup_done), .lookup_hit(lookup_hit), .lookup_result(lookup_result));

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`include "twp_defines.svh"

module tb_top;
  import twp_pkg::*;
  typedef struct {
    logic        tsel;
    logic [15:0] addr;
    logic [31:0] val0, val1, msk0, msk1, seed;
    logic [51:0] flip;
    logic        hit;
  } twp_row_t;

  logic         clk, rst_n, ce, hsel, hwrite, hreadyout, hresp, lookup_done, lookup_hit;
  logic [31:0]  haddr, hwdata, hrdata, rd;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [488:0] lookup_result;
  twp_lookup_t  lookup_req;
  int           n_mismatch, checks;
  twp_row_t     rows [7];
  logic [31:0]  wofs [4] = '{`TWP_OFS_VAL0, `TWP_OFS_MSK1, `TWP_OFS_ACT15, `TWP_OFS_CNT};

  // single slave: its ready is the bus ready
  twp_rule_write_port #(.CLM_DEPTH(64)) dut_u (
    .clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .lookup_req(lookup_req), .lookup_done(lookup_done), .lookup_hit(lookup_hit),
    .lookup_result(lookup_result));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // bus, lookup and compare tasks
  // ----------------------------------------
  task automatic cmp_vec(input string nm, input logic [488:0] exp, input logic [488:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    {hsel, htrans, haddr, hwrite} <= {1'h1, `TWP_HTRANS_NONSEQ, a, wr};
    do @(posedge clk); while (hreadyout !== 1'h1);
    {hsel, htrans, hwdata} <= {1'h0, 2'h0, d};
    do @(posedge clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task automatic commit(input logic ts, input logic [15:0] a, input logic wipe);
    bus(1'h1, `TWP_OFS_CTRL, {11'h0, wipe, ts, a, `TWP_CMD_WRITE});
  endtask
  // bounded by the watchdog rather than a local count
  task automatic wait_idle;
    rd = 32'h0020_0000;
    while (rd[`TWP_BUSY_BIT] !== 1'h0) bus(1'h0, `TWP_OFS_CTRL, 32'h0);
  endtask
  task automatic look(input logic ts, input logic [15:0] a, input logic [51:0] k, input logic hit,
                      input logic [488:0] res);
    @(posedge clk);
    lookup_req <= '{valid: 1'h1, tsel: ts, addr: a, key: k};
    @(posedge clk);
    lookup_req.valid <= 1'h0;
    repeat (2) @(posedge clk);
    cmp_vec("lookup_done", 489'h1, {488'h0, lookup_done});
    cmp_vec("lookup_hit", {488'h0, hit}, {488'h0, lookup_hit});
    cmp_vec("lookup_result", res, lookup_result);
  endtask
  function automatic logic [488:0] exp_res(input logic ts, input logic [31:0] seed);
    logic [511:0] w;
    for (int i = 0; i < 16; i++) w[i*32 +: 32] = seed + i * 32'h1111_1111;
    return ts ? w[488:0] : {379'h0, w[109:0]};
  endfunction
  function automatic logic [51:0] key_of(input twp_row_t r);
    return (r.tsel ? {1'h0, r.val1[18:0], r.val0} : {r.val1[19:0], r.val0}) ^ r.flip;
  endfunction
  task automatic test_done;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk);
    n_mismatch++;
    test_done;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst_n, ce, hsel, hwrite, haddr, htrans, hsize, hwdata} = {1'h0, 1'h1, 1'h0, 1'h0, 32'h0, 2'h0, 3'h2, 32'h0};
    lookup_req = '0;
    n_mismatch = 0;
    checks = 0;
    rows = '{'{1'h0, 16'h0008, 32'h8765_4322, 32'h0005_5555, 32'h0, 32'h0, 32'h0000_0008, 52'h1, 1'h0},
             '{1'h0, 16'h0007, 32'h0F0F_0F02, 32'h0001_2345, 32'h0000_FF00, 32'h0, 32'h5A00_0000,
               52'h3C00, 1'h1},
             '{1'h0, 16'h0006, 32'h1234_5672, 32'h000A_BCDE, 32'h0, 32'h0, 32'hA5A5_0004, 52'h0, 1'h1},
             '{1'h0, 16'h003F, 32'hFFFF_FFFE, 32'h000F_FFFF, 32'h0, 32'h0008_0000, 32'hFFFF_FFFF,
               52'h8_0000_0000_0000, 1'h1},
             '{1'h1, 16'h04BF, 32'hC0FF_EE00, 32'hFFF8_1234, 32'h0, 32'h0, 32'h1357_9BDF, 52'h0, 1'h1},
             '{1'h1, 16'h0000, 32'h0000_0001, 32'h0, 32'h0, 32'h0, 32'h2468_ACE0, 52'h0, 1'h1},
             '{1'h1, 16'h0FFF, 32'h1111_2222, 32'h0007_FFFF, 32'h0, 32'h0, 32'h0F0F_0F0F,
               52'h8_0000_0000_0000, 1'h1}};
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    bus(1'h0, `TWP_OFS_CTRL, 32'h0);
    cmp_vec("ctrl_reset", 489'h0, {457'h0, rd});
    foreach (rows[n]) begin
      bus(1'h1, `TWP_OFS_CTRL, 32'h0010_0000);
      {haddr, hwdata} <= {haddr, hwdata};
      bus(1'h1, `TWP_OFS_VAL0, rows[n].val0);
      bus(1'h1, `TWP_OFS_VAL1, rows[n].val1);
      bus(1'h1, `TWP_OFS_MSK0, rows[n].msk0);
      bus(1'h1, `TWP_OFS_MSK1, rows[n].msk1);
      for (int i = 0; i < 16; i++) bus(1'h1, 32'(`TWP_OFS_ACT0 + 4 * i), rows[n].seed + i * 32'h1111_1111);
      commit(rows[n].tsel, rows[n].addr, 1'h0);
      wait_idle;
      look(rows[n].tsel, rows[n].addr, key_of(rows[n]), rows[n].hit, rows[n].hit ? exp_res(rows[n].tsel,
           rows[n].seed) : 489'h0);
    end
    commit(1'h0, 16'h000A, 1'h0);
    bus(1'h0, `TWP_OFS_CTRL, 32'h0);
    cmp_vec("ctrl_busy", 489'h1, {488'h0, rd[`TWP_BUSY_BIT]});
    wait_idle;
    // clock enable low: the bus write must be lost and a running commit must stall
    ce <= 1'h0;
    bus(1'h1, `TWP_OFS_VAL0, 32'h0000_00FF);
    ce <= 1'h1;
    bus(1'h0, `TWP_OFS_VAL0, 32'h0);
    cmp_vec("val0_ce_low", {457'h0, rows[6].val0}, {457'h0, rd});
    commit(1'h0, 16'h000C, 1'h0);
    ce <= 1'h0;
    repeat (10) @(posedge clk);
    ce <= 1'h1;
    bus(1'h0, `TWP_OFS_CTRL, 32'h0);
    cmp_vec("ctrl_ce_frozen", 489'h1, {488'h0, rd[`TWP_BUSY_BIT]});
    wait_idle;
    commit(1'h0, 16'h000B, 1'h1);
    bus(1'h1, `TWP_OFS_VAL0, 32'hDEAD_BEEF);
    wait_idle;
    bus(1'h0, `TWP_OFS_VAL0, 32'h0);
    cmp_vec("val0_busy_write", 489'h0, {457'h0, rd});
    foreach (wofs[i]) bus(1'h1, wofs[i], 32'h0000_0001);
    bus(1'h0, `TWP_OFS_ACT15, 32'h0);
    cmp_vec("act15_write", 489'h1, {457'h0, rd});
    bus(1'h1, `TWP_OFS_CTRL, 32'h0010_0000);
    foreach (wofs[i]) begin
      bus(1'h0, wofs[i], 32'h0);
      cmp_vec("wiped_word", 489'h0, {457'h0, rd});
    end
    commit(1'h0, 16'h0006, 1'h1);
    wait_idle;
    look(1'h0, 16'h0006, key_of(rows[2]), 1'h0, 489'h0);
    look(1'h1, 16'h1000, key_of(rows[5]), 1'h0, 489'h0);
    look(1'h0, 16'h0040, 52'h0, 1'h0, 489'h0);
    bus(1'h0, 32'h0000_1000, 32'h0);
    cmp_vec("unmapped", 489'h0, {457'h0, rd});
    bus(1'h1, `TWP_OFS_VAL0, 32'h0000_00FF);
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    bus(1'h0, `TWP_OFS_VAL0, 32'h0);
    cmp_vec("val0_after_reset", 489'h0, {457'h0, rd});
    test_done;
  end
endmodule
